// >>> rst_seq.sv
// Purpose: Defers a reset request past a RAM write, then emits a fixed pulse
// Assumes: Pulse length counted in machine cycles, which equal core_clk here
// Notes: Busy covers both the wait and the pulse
`timescale 1ns/10ps
module rst_seq
(
  input wire logic core_clk, // Clock
  input wire logic sys_rst, // Async reset, active high
  sup_if.seq sif // Request and pulse
);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  sup_pkg::rst_state_t state;
  sup_pkg::rst_state_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;

  // Next state: wait while the RAM write is still open
  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      sup_pkg::ST_IDLE:
      begin
        if (sif.req)
        begin
          next_state = sif.ram_wr ? sup_pkg::ST_WAIT : sup_pkg::ST_PULSE;
          next_cnt = 3'(sup_pkg::RST_PULSE_MCYC - 1);
        end
      end
      sup_pkg::ST_WAIT:
      begin
        if (!sif.ram_wr)
          next_state = sup_pkg::ST_PULSE;
      end
      sup_pkg::ST_PULSE:
      begin
        if (cnt == 3'h0)
          next_state = sup_pkg::ST_IDLE;
        else
          next_cnt = cnt - 3'h1;
      end
      default:
        next_state = sup_pkg::ST_IDLE;
    endcase
  end

  // Registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state <= sup_pkg::ST_IDLE;
      cnt <= 3'h0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  assign sif.busy = (state != sup_pkg::ST_IDLE);
  assign sif.rst_out = (state == sup_pkg::ST_PULSE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_pulse_start;
    $rose(sif.rst_out);
  endsequence

  chk_pulse_width: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_pulse_start |-> sif.rst_out [*5] ##1 !sif.rst_out)
    else $error("Reset pulse is not five cycles wide");

  chk_defer_write: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sif.ram_wr && !sif.rst_out) |=> !sif.rst_out)
    else $error("Reset pulse started during a RAM write");

endmodule

// >>> sup_if.sv
// Purpose: Carries the reset request between the top and the pulse sequencer
// Assumes: Single clock domain
// Notes: Request is a pulse of up to two cycles, busy is a level
`timescale 1ns/10ps
interface sup_if;
  logic req;
  logic ram_wr;
  logic busy;
  logic rst_out;
  modport top (output req, output ram_wr, input busy, input rst_out);
  modport seq (input req, input ram_wr, output busy, output rst_out);
endinterface

// >>> sup_pkg.sv
// Purpose: Shared constants for the supply and loop supervisor
// Assumes: core_clk at 125 MHz, oscillator sampled as a synchronous enable input
// Notes: Counts are cycles of core_clk unless stated otherwise
package sup_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ = 125;
  localparam int LOOP_CNT_W = 20;
  localparam int RST_PULSE_MCYC = 5;
  localparam int STBY_EXTRA_US = 20;
  localparam int STBY_EXTRA_CYC = STBY_EXTRA_US * CLK_MHZ;
  localparam logic [LOOP_CNT_W-1:0] LOOP_CNT_RST = 20'h0_0000;

  // Reset sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_PULSE = 2'b10
  } rst_state_t;

endpackage

// >>> sup_top.sv
// Purpose: Low-voltage reset and program loop watchdog reset supervisor
// Assumes: Oscillator edge arrives as a one-cycle enable synchronous to core_clk
// Notes: Supervisor control register is modelled as a write strobe and data bit
`timescale 1ns/10ps

// Contract
// - Low voltage sets flag and requests reset
// - Detector works in stop, reset ends stop
// - Defer reset until RAM write completes
// - Mask detector output during deferred reset
// - 20-bit counter on oscillator, starts after power-on
// - Counter overflow triggers internal reset
// - Loop reset lasts five machine cycles
// - Standby recovery adds twenty microseconds; none if recovery starts straight out of power-on
// - No counting while processor halted
// - Writing zero to clear bit clears counter
// - Reset or oscillator stop clears counter
// - Sleep, timebase or clock mode entry clears
module sup_top
#(
  parameter int LOOP_W = sup_pkg::LOOP_CNT_W, // Counter width
  parameter int STBY_EXTRA = sup_pkg::STBY_EXTRA_CYC // Extra wait after standby
)
(
  input wire logic core_clk, // Machine clock
  input wire logic sys_rst, // Power-on reset, active high
  input wire logic osc_tick, // One pulse per oscillator period
  input wire logic osc_stopped, // Main oscillator stopped
  input wire logic low_volt, // Comparator says supply is low
  input wire logic ram_wr, // Internal RAM write in progress
  input wire logic cpu_halted, // CPU not running
  input wire logic enter_sleep, // Pulse: entering sleep mode
  input wire logic enter_tbt, // Pulse: entering timebase timer mode
  input wire logic enter_clkmode, // Pulse: entering clock mode
  input wire logic stby_recover, // Level: recovering from standby
  input wire logic stop_mode, // Device in stop mode
  input wire logic clr_wr, // Write strobe to counter_clear_bit
  input wire logic clr_data, // Value written to counter_clear_bit
  input wire logic flag_clr, // Software clears low_voltage_flag
  output logic low_voltage_flag, // Sticky low-voltage flag
  output logic int_rst, // Internal reset to the core
  output logic stop_release, // Pulse: leave stop mode
  output logic loop_rst_cause // Last reset came from the watchdog
);

  // ----------------------------------------------------------------
  // Local state
  // ----------------------------------------------------------------
  // Width of the standby extension counter, sized from its reload value
  localparam int EXTRA_W = $clog2(STBY_EXTRA + 1);

  sup_if sif ();
  logic [LOOP_W-1:0] loop_cnt;
  logic [LOOP_W-1:0] next_loop_cnt;
  logic [EXTRA_W-1:0] extra_cnt;
  logic [EXTRA_W-1:0] next_extra_cnt;
  logic next_flag;
  logic next_cause;
  logic next_stop_release;
  logic lv_req;
  logic loop_req;
  logic req_q;
  logic next_req;
  logic cnt_clear;
  logic cnt_full;
  logic next_int_rst;

  // Low-power mode entries that restart the loop count; shared by logic and checks
  function automatic logic mode_entry
  (
    input logic sleep_in, // Entering sleep mode
    input logic tbt_in, // Entering timebase timer mode
    input logic clk_in // Entering clock mode
  );
    mode_entry = sleep_in || tbt_in || clk_in;
  endfunction

  rst_seq u_seq (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .sif(sif)
  );

  // ----------------------------------------------------------------
  // Reset requests
  // ----------------------------------------------------------------
  // Detector is ignored while a reset is already on its way
  assign lv_req = low_volt && !sif.busy;
  assign cnt_full = (loop_cnt == {LOOP_W{1'b1}});
  // Standby recovery holds the trip until the extra window expires
  assign loop_req = cnt_full && osc_tick && !cpu_halted
    && (!stby_recover || extra_cnt == '0) && !sif.busy;
  assign sif.req = req_q;
  assign sif.ram_wr = ram_wr;

  // Clear sources; a one written to the clear bit is ignored
  assign cnt_clear = (clr_wr && !clr_data)
    || sif.busy || osc_stopped
    || mode_entry(enter_sleep, enter_tbt, enter_clkmode);

  // ----------------------------------------------------------------
  // Loop counter
  // ----------------------------------------------------------------
  // Any clear source wins over a tick; the count parks at all ones until it trips
  always_comb
  begin
    next_loop_cnt = loop_cnt;
    if (cnt_clear)
      next_loop_cnt = '0;
    else if (osc_tick && !cpu_halted && !cnt_full)
      next_loop_cnt = loop_cnt + 1'b1;
  end

  // Power-on reset leaves the count ready to run with no software help
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      loop_cnt <= LOOP_W'(sup_pkg::LOOP_CNT_RST);
    else
      loop_cnt <= next_loop_cnt;
  end

  // ----------------------------------------------------------------
  // Standby extension
  // ----------------------------------------------------------------
  // Reloaded in normal running, drained while recovering from standby
  always_comb
  begin
    next_extra_cnt = extra_cnt;
    if (!stby_recover)
      next_extra_cnt = EXTRA_W'(STBY_EXTRA);
    else if (extra_cnt != '0)
      next_extra_cnt = extra_cnt - 1'b1;
  end

  // Starts drained, so recovery straight out of power-on adds no delay
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
      extra_cnt <= '0;
    else
      extra_cnt <= next_extra_cnt;
  end

  // ----------------------------------------------------------------
  // Flag and cause
  // ----------------------------------------------------------------
  // Set beats clear so a drop outside a reset sequence is never lost
  always_comb
  begin
    next_flag = low_voltage_flag;
    next_cause = loop_rst_cause;
    if (flag_clr)
      next_flag = 1'b0;
    if (lv_req)
      next_flag = 1'b1;
    // Cause bit lets software tell a runaway from a supply drop
    if (loop_req)
      next_cause = 1'b1;
    else if (lv_req)
      next_cause = 1'b0;
  end

  // Flag and cause registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      low_voltage_flag <= 1'b0;
      loop_rst_cause <= 1'b0;
    end
    else
    begin
      low_voltage_flag <= next_flag;
      loop_rst_cause <= next_cause;
    end
  end

  // ----------------------------------------------------------------
  // Request and outputs
  // ----------------------------------------------------------------
  // Outputs leave a flop, which costs one cycle of reset latency
  always_comb
  begin
    next_req = lv_req || loop_req;
    next_int_rst = sif.rst_out;
    next_stop_release = lv_req && stop_mode;
  end

  // Request and output registers
  always_ff @(posedge core_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      req_q <= 1'b0;
      int_rst <= 1'b0;
      stop_release <= 1'b0;
    end
    else
    begin
      req_q <= next_req;
      int_rst <= next_int_rst;
      stop_release <= next_stop_release;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_lv_flag_set: assert property (@(posedge core_clk) disable iff (sys_rst)
    lv_req |=> low_voltage_flag)
    else $error("Low-voltage flag not set");

  chk_lv_reset: assert property (@(posedge core_clk) disable iff (sys_rst)
    (lv_req && !ram_wr) |-> ##3 int_rst)
    else $error("Low-voltage reset missing");

  chk_stop_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
    (lv_req && stop_mode) |=> stop_release)
    else $error("Stop mode not released");

  chk_lv_mask: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sif.busy && !low_voltage_flag) |=> !low_voltage_flag)
    else $error("Detector not masked");

  chk_halt_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cpu_halted && !cnt_clear) |=> $stable(loop_cnt))
    else $error("Counter moved while halted");

  chk_clear_zero: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clr_wr && !clr_data) |=> loop_cnt == '0)
    else $error("Clear write ignored");

  chk_clear_one: assert property (@(posedge core_clk) disable iff (sys_rst)
    (clr_wr && clr_data && !cnt_clear && !osc_tick) |=> $stable(loop_cnt))
    else $error("Writing one disturbed counter");

  chk_mode_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    (mode_entry(enter_sleep, enter_tbt, enter_clkmode) || osc_stopped) |=> loop_cnt == '0)
    else $error("Mode entry did not clear counter");

  chk_trip: assert property (@(posedge core_clk) disable iff (sys_rst)
    loop_req |=> ##1 sif.busy)
    else $error("Overflow did not start reset");

  chk_cause_loop: assert property (@(posedge core_clk) disable iff (sys_rst)
    loop_req |=> loop_rst_cause)
    else $error("Watchdog cause not recorded");

  chk_cause_lv: assert property (@(posedge core_clk) disable iff (sys_rst)
    (lv_req && !loop_req) |=> !loop_rst_cause)
    else $error("Low-voltage cause not recorded");

  chk_cnt_step: assert property (@(posedge core_clk) disable iff (sys_rst)
    (osc_tick && !cpu_halted && !cnt_clear && !cnt_full)
      |=> loop_cnt == LOOP_W'($past(loop_cnt) + 1'b1))
    else $error("Counter did not advance on a tick");

  chk_cnt_sat: assert property (@(posedge core_clk) disable iff (sys_rst)
    (cnt_full && !cnt_clear) |=> cnt_full)
    else $error("Full counter wrapped without a clear");

  chk_tick_only: assert property (@(posedge core_clk) disable iff (sys_rst)
    (!osc_tick && !cnt_clear) |=> $stable(loop_cnt))
    else $error("Counter moved without a tick");

  chk_busy_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    sif.busy |=> loop_cnt == '0)
    else $error("Internal reset did not clear counter");

  chk_stby_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (stby_recover && extra_cnt != '0 && !low_volt) |=> !req_q)
    else $error("Trip inside standby extension");

  chk_flag_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (low_voltage_flag && !flag_clr) |=> low_voltage_flag)
    else $error("Low-voltage flag dropped by itself");

  chk_flag_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
    (flag_clr && !lv_req) |=> !low_voltage_flag)
    else $error("Low-voltage flag not cleared");

  chk_mask_wake: assert property (@(posedge core_clk) disable iff (sys_rst)
    sif.busy |=> !stop_release)
    else $error("Masked detector released stop mode");

  chk_release_src: assert property (@(posedge core_clk) disable iff (sys_rst)
    $rose(stop_release) |-> $past(stop_mode))
    else $error("Stop release outside stop mode");

  chk_wait_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
    (sif.busy && !sif.rst_out) |=> !int_rst)
    else $error("Internal reset during a deferred wait");

  // The output reset is the sequencer pulse one register later
  sequence s_rst_rise;
    $rose(int_rst);
  endsequence

  sequence s_rst_body;
    int_rst [*5] ##1 !int_rst;
  endsequence

  chk_out_width: assert property (@(posedge core_clk) disable iff (sys_rst)
    s_rst_rise |-> s_rst_body)
    else $error("Internal reset is not five cycles wide");

endmodule

// >>> sup_top_tb.sv
// Purpose: Self-checking bench for the supply and loop supervisor
// Assumes: Shortened counts, inputs driven on the falling edge of core_clk
// Notes: An integer model of the loop counter predicts every watchdog trip except the one in the standby recovery test
`timescale 1ns/10ps
module sup_top_tb_top;
  // ----------------------------------------------------------------
  // Stimulus and model state
  // ----------------------------------------------------------------
  localparam int LW = 4;
  localparam int TRIP = 1 << LW;
  localparam int STBY = 40;
  logic core_clk, sys_rst, osc_tick, osc_stopped, low_volt, ram_wr, cpu_halted;
  logic enter_sleep, enter_tbt, enter_clkmode, stby_recover, stop_mode;
  logic clr_wr, clr_data, flag_clr, low_voltage_flag, int_rst, stop_release, loop_rst_cause;
  int errors = 0;
  int n_checks = 0;
  int cnt = 0;
  int t, r;

  sup_top #(.LOOP_W(LW), .STBY_EXTRA(STBY)) dut (.core_clk(core_clk), .sys_rst(sys_rst),
    .osc_tick(osc_tick), .osc_stopped(osc_stopped), .low_volt(low_volt), .ram_wr(ram_wr),
    .cpu_halted(cpu_halted), .enter_sleep(enter_sleep), .enter_tbt(enter_tbt),
    .enter_clkmode(enter_clkmode), .stby_recover(stby_recover), .stop_mode(stop_mode),
    .clr_wr(clr_wr), .clr_data(clr_data), .flag_clr(flag_clr),
    .low_voltage_flag(low_voltage_flag), .int_rst(int_rst), .stop_release(stop_release),
    .loop_rst_cause(loop_rst_cause));

  // 125 MHz machine clock
  initial
  begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Waits for a reset pulse, measures it; poke tries to clear and re-set the flag inside it
  task automatic pulse_chk(input logic cause, input logic poke, output int waited);
    int w;
    w = 0;
    waited = 0;
    while (int_rst !== 1'b1 && waited < 80)
    begin
      @(negedge core_clk);
      waited++;
    end
    while (int_rst === 1'b1 && w < 20)
    begin
      flag_clr = poke && w == 0;
      low_volt = poke && w == 2;
      @(negedge core_clk);
      w++;
    end
    low_volt = 1'b0;
    chk(w, 5);
    chk(loop_rst_cause, cause);
    cnt = 0;
  endtask

  // One oscillator tick at a time; the model predicts when the counter trips
  task automatic tick(input int n);
    for (int i = 0; i < n; i++)
    begin
      osc_tick = 1'b1;
      @(negedge core_clk);
      osc_tick = 1'b0;
      if (cpu_halted !== 1'b1)
        cnt++;
      if (cnt == TRIP)
        pulse_chk(1'b1, 1'b0, t);
      else
      begin
        repeat (3) @(negedge core_clk);
        chk(int_rst, 1'b0);
      end
    end
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    {osc_tick, osc_stopped, low_volt, ram_wr, cpu_halted, enter_sleep} = '0;
    {enter_tbt, enter_clkmode, stby_recover, stop_mode, clr_wr, clr_data, flag_clr} = '0;
    sys_rst = 1'b1;
    void'($urandom(32524));
    repeat (4) @(negedge core_clk);
    sys_rst = 1'b0;
    @(negedge core_clk);
    // Low supply in stop mode: flag, stop release, then reset pulse
    stop_mode = 1'b1;
    low_volt = 1'b1;
    @(negedge core_clk);
    low_volt = 1'b0;
    chk(low_voltage_flag, 1'b1);
    chk(stop_release, 1'b1);
    pulse_chk(1'b0, 1'b0, t);
    stop_mode = 1'b0;
    chk(low_voltage_flag, 1'b1);
    flag_clr = 1'b1;
    @(negedge core_clk);
    flag_clr = 1'b0;
    @(negedge core_clk);
    chk(low_voltage_flag, 1'b0);
    // Request during a RAM write is held back until the write ends
    ram_wr = 1'b1;
    low_volt = 1'b1;
    @(negedge core_clk);
    low_volt = 1'b0;
    chk(stop_release, 1'b0);
    repeat ($urandom_range(8, 3))
    begin
      @(negedge core_clk);
      chk(int_rst, 1'b0);
    end
    ram_wr = 1'b0;
    pulse_chk(1'b0, 1'b1, t);
    chk(t <= 3, 1'b1);
    chk(low_voltage_flag, 1'b0);
    repeat (10) @(negedge core_clk);
    chk(int_rst, 1'b0);
    // Halted CPU freezes the count, then an exact trip
    cpu_halted = 1'b1;
    tick(10);
    cpu_halted = 1'b0;
    tick(TRIP);
    // Every clear source but an internal reset, and a write of one that must not clear
    for (int s = 0; s < 6; s++)
    begin
      r = $urandom_range(TRIP - 2, 1);
      tick(r);
      case (s)
        0: {clr_wr, clr_data} = 2'b10;
        1: osc_stopped = 1'b1;
        2: enter_sleep = 1'b1;
        3: enter_tbt = 1'b1;
        4: enter_clkmode = 1'b1;
        default: {clr_wr, clr_data} = 2'b11;
      endcase
      @(negedge core_clk);
      {clr_wr, clr_data, osc_stopped, enter_sleep, enter_tbt, enter_clkmode} = '0;
      if (s < 5)
        cnt = 0;
      tick(TRIP - cnt);
    end
    // Standby recovery: trip no earlier than the extra window
    stby_recover = 1'b1;
    osc_tick = 1'b1;
    t = 0;
    while (int_rst !== 1'b1 && t < STBY + 40)
    begin
      @(negedge core_clk);
      t++;
    end
    osc_tick = 1'b0;
    stby_recover = 1'b0;
    chk(t >= STBY && t < STBY + 40, 1'b1);
    pulse_chk(1'b1, 1'b0, t);
    results();
  end

  // Cuts a hang short, well past the expected run of under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk);
    errors++;
    results();
  end
endmodule
